// ### pkg/io_group_pkg.sv
package io_group_pkg;

  // I/O timing states, one-hot codes
  typedef enum logic [5:0] {
    IO_T1 = 6'h01,
    IO_T2 = 6'h02,
    IO_T3 = 6'h04,
    IO_T4 = 6'h08,
    IO_T5 = 6'h10,
    IO_T6 = 6'h20
  } io_time_type;

  // Microroutine sequencer states, one-hot codes
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_WAIT = 4'h2,
    SEQ_RUN = 4'h4,
    SEQ_FIN = 4'h8
  } seq_state_type;

  // Octal group codes from IR8..IR6
  localparam logic [2:0] GRP_HALT = 3'h0;
  localparam logic [2:0] GRP_FLAG = 3'h1;
  localparam logic [2:0] GRP_SKIP_CLEAR = 3'h2;
  localparam logic [2:0] GRP_SKIP_SET = 3'h3;
  localparam logic [2:0] GRP_MERGE = 3'h4;
  localparam logic [2:0] GRP_LOAD = 3'h5;
  localparam logic [2:0] GRP_OUTPUT = 3'h6;
  localparam logic [2:0] GRP_CONTROL = 3'h7;

  // Instruction register field positions
  localparam int IR_GRP_LO = 6;
  localparam int IR_GRP_HI = 8;
  localparam int IR_CLEAR_FLAG = 9;
  localparam int IR_AB_SEL = 11;
  localparam int IR_WIDTH = 16;

  // Microprogram entry points
  localparam logic [7:0] UADDR_FLAG = 8'h20;
  localparam logic [7:0] UADDR_MERGE = 8'h28;
  localparam logic [7:0] UADDR_LOAD = 8'h30;
  localparam logic [7:0] UADDR_OUTPUT = 8'h38;
  localparam logic [7:0] UADDR_CTRL = 8'h3C;
  localparam logic [7:0] UADDR_LAST = 8'h3F;

  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 16;
  localparam logic [ADDR_WIDTH-1:0] SRC_RESET = 6'h00;

  // Request flop may drop only in the last 100 ns of phase 1B
  localparam int CLK_PERIOD_NS = 20;
  localparam int REQ_CLEAR_WINDOW_NS = 100;
  localparam int REQ_CLEAR_CYCLES = REQ_CLEAR_WINDOW_NS / CLK_PERIOD_NS;

  function automatic logic [7:0] octal_onehot(input logic [2:0] code);
    octal_onehot = 8'h01 << code;
  endfunction

endpackage

// ### hdl/io_timing_gen.sv
`timescale 1ns/1ps
module io_timing_gen
  import io_group_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ioAdvance,
  output io_time_type ioTime
);

  io_time_type time_reg;
  io_time_type time_next;

  // I/O time ring runs T1..T6 on each advance strobe
  always_comb begin
    time_next = time_reg;
    if (ioAdvance) begin
      case (time_reg)
        IO_T1: time_next = IO_T2;
        IO_T2: time_next = IO_T3;
        IO_T3: time_next = IO_T4;
        IO_T4: time_next = IO_T5;
        IO_T5: time_next = IO_T6;
        IO_T6: time_next = IO_T1;
        default: time_next = IO_T1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      time_reg <= IO_T1;
    end else begin
      time_reg <= time_next;
    end
  end

  assign ioTime = time_reg;

endmodule

// ### hdl/interrupt_source_reg.sv
`timescale 1ns/1ps
module interrupt_source_reg
  import io_group_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic captureEn,
  input wire logic [ADDR_WIDTH-1:0] requestAddr,
  output logic [ADDR_WIDTH-1:0] sourceAddr
);

  logic [ADDR_WIDTH-1:0] addr_reg;

  // Held until the next interrupt fetch recaptures it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= SRC_RESET;
    end else if (captureEn) begin
      addr_reg <= requestAddr; // [RL1] [RL5]
    end
  end

  assign sourceAddr = addr_reg;

endmodule

// ### hdl/io_group_decoder.sv
`timescale 1ns/1ps
// Functional notes
// [RL1] Six-bit source register captures the encoded request address.
// [RL2] Register clocks at T6 of fetch phase 1B and drives S-bus then.
// [RL3] Request address stays valid; request clears only in last 100 ns.
// [RL4] Read-source code in first 1B microinstruction gates address to S-bus.
// [RL5] Load input from code 04 returns the last interrupting address.
// [RL6] Input strobe true T4-T5; with code 4 gates source register out.
// [RL7] I/O instructions use five microroutines in the I/O address range.
// [RL8] Flag and control routines use the shared low and high addresses.
// [RL9] Sync code stalls CPU clocks until T2 and executes held there.
// [RL10] Group enable true from T3 to end of T6, absent violation.
// [RL11] IR8..IR6 decode to one octal line; IR9, IR11 refine it.
// [RL12] Code 7 at T4 gives set/clear control per IR11 with destinations.
// [RL13] Clear control to code 01 broadcasts control reset to all cards.
// [RL14] Code 3 gives skip-if-set T3-T6 testing per select code.
// [RL15] Code 2 gives skip-if-clear, also testing power-fail direction at 04.
// [RL16] Code 1 at T3 gives set flag to its destinations.
// [RL17] IR9 at T4 forms clear flag, undoing the T3 set.
// [RL18] Code 6 gives output strobe in T3T4 to its destinations.
// [RL19] Data transfer in phase 3 vectors to merge, load or output routine.
// [RL20] Merge asserts read buffer in last two steps, T4 and T5.
// [RL21] Merge ORs selected accumulator with input data at the end.
// [RL22] Load is as merge without reading the accumulator.
// [RL23] Output drives accumulator onto I/O bus in T4 and T5.
// [RL24] One-hot select inputs qualify every strobe destination; interruptInhibitClear is not select-qualified.
module io_group_decoder
  import io_group_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ioAdvance,
  input wire logic [IR_WIDTH-1:0] instrReg,
  input wire logic execPhase,
  input wire logic fetchPhase1B,
  input wire logic io_group_sync_code,
  input wire logic interrupt_source_read_code,
  input wire logic ioViolation,
  input wire logic sel00,
  input wire logic sel01,
  input wire logic select_code_four,
  input wire logic sel05,
  input wire logic sel06,
  input wire logic sel07,
  input wire logic cardSelect,
  input wire logic [ADDR_WIDTH-1:0] requestAddr,
  input wire logic card_flag_signal,
  input wire logic overflow_not_flop,
  input wire logic dma1_flag,
  input wire logic dma2_flag,
  input wire logic powerfail_direction_flop,
  input wire logic [DATA_WIDTH-1:0] accA,
  input wire logic [DATA_WIDTH-1:0] accB,
  input wire logic [DATA_WIDTH-1:0] io_data_lines_in,
  output logic cpuClockHold,
  output logic io_group_enable,
  output logic [7:0] microAddr,
  output logic set_control_instr,
  output logic clear_control_instr,
  output logic control_reset_broadcast,
  output logic interruptInhibitClear,
  output logic control4Set,
  output logic dma1ControlSet,
  output logic dma1ControlClear,
  output logic dma2ControlSet,
  output logic dma2ControlClear,
  output logic cardControlSet,
  output logic cardControlClear,
  output logic skipFlag,
  output logic set_flag_strobe,
  output logic clear_flag_strobe,
  output logic overflowSet,
  output logic interruptEnableSet,
  output logic interruptEnableClear,
  output logic dma1FlagBufSet,
  output logic dma2FlagBufSet,
  output logic cardFlagBufSet,
  output logic output_strobe,
  output logic fenceLoad,
  output logic dmaControlLoad1,
  output logic dmaControlLoad2,
  output logic panelLoad,
  output logic cardDataLoad,
  output logic input_strobe,
  output logic read_io_buffer,
  output logic send_io_buffer,
  output logic read_interrupt_source,
  output logic [DATA_WIDTH-1:0] sBus,
  output logic [DATA_WIDTH-1:0] io_data_lines_out,
  output logic io_data_lines_oe,
  output logic [DATA_WIDTH-1:0] accWriteData,
  output logic accAWrite,
  output logic accBWrite,
  output logic requestClear
);

  io_time_type ioTime;
  seq_state_type seq_reg;
  seq_state_type seq_next;
  logic [ADDR_WIDTH-1:0] sourceAddr;
  logic [7:0] octal;
  logic [2:0] grp;
  logic isT3, isT4, isT5, isT6;
  logic groupLive, captureEn, readSrcNow, inSrc, mergeOp;
  logic [DATA_WIDTH-1:0] accSel, srcWord, sBus_next;
  logic [2:0] reqCnt_reg;
  logic [7:0] uaddr_reg;

  assign grp = instrReg[IR_GRP_HI:IR_GRP_LO];
  assign octal = octal_onehot(grp); // [RL11]
  assign isT3 = ioTime == IO_T3;
  assign isT4 = ioTime == IO_T4;
  assign isT5 = ioTime == IO_T5;
  assign isT6 = ioTime == IO_T6;
  assign accSel = instrReg[IR_AB_SEL] ? accB : accA;
  assign srcWord = {{(DATA_WIDTH-ADDR_WIDTH){1'b0}},
                    (captureEn ? requestAddr : sourceAddr)}; // [RL2]
  assign captureEn = fetchPhase1B && isT6 && ioAdvance; // [RL2]
  assign readSrcNow = fetchPhase1B && isT6 && interrupt_source_read_code;
  assign groupLive = (seq_reg == SEQ_RUN) && (isT3 || isT4 || isT5 || isT6)
                     && !ioViolation; // [RL10]
  assign inSrc = select_code_four && (isT4 || isT5)
                 && (octal[GRP_LOAD] || octal[GRP_MERGE]); // [RL6]
  assign mergeOp = octal[GRP_MERGE];

  io_timing_gen timing (
    .clk(clk),
    .rst_b(rst_b),
    .ioAdvance(ioAdvance),
    .ioTime(ioTime)
  );

  interrupt_source_reg srcReg (
    .clk(clk),
    .rst_b(rst_b),
    .captureEn(captureEn),
    .requestAddr(requestAddr),
    .sourceAddr(sourceAddr)
  );

  // Sync code freezes CPU until T2, then routine runs T3..T6
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: if (io_group_sync_code) seq_next = SEQ_WAIT; // [RL9]
      SEQ_WAIT: if (ioTime == IO_T2) seq_next = SEQ_RUN; // [RL9]
      SEQ_RUN: if (isT6 && ioAdvance) seq_next = SEQ_FIN; // [RL10]
      SEQ_FIN: seq_next = SEQ_IDLE;
      default: seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuClockHold <= 1'b0;
      io_group_enable <= 1'b0;
    end else begin
      cpuClockHold <= seq_next == SEQ_WAIT; // [RL9]
      io_group_enable <= groupLive; // [RL10]
    end
  end

  // Mapper entry for each I/O microroutine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uaddr_reg <= UADDR_FLAG;
    end else if (execPhase) begin
      case (grp)
        GRP_MERGE: uaddr_reg <= UADDR_MERGE; // [RL19] [RL7]
        GRP_LOAD: uaddr_reg <= UADDR_LOAD; // [RL19] [RL7]
        GRP_OUTPUT: uaddr_reg <= UADDR_OUTPUT; // [RL19] [RL7]
        GRP_CONTROL: uaddr_reg <= UADDR_CTRL; // [RL8]
        default: uaddr_reg <= UADDR_FLAG; // [RL8]
      endcase
    end
  end
  assign microAddr = uaddr_reg;

  // Control and flag strobes with their destinations
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      set_control_instr <= 1'b0;
      clear_control_instr <= 1'b0;
      control_reset_broadcast <= 1'b0;
      interruptInhibitClear <= 1'b0;
      control4Set <= 1'b0;
      dma1ControlSet <= 1'b0;
      dma1ControlClear <= 1'b0;
      dma2ControlSet <= 1'b0;
      dma2ControlClear <= 1'b0;
      cardControlSet <= 1'b0;
      cardControlClear <= 1'b0;
      set_flag_strobe <= 1'b0;
      clear_flag_strobe <= 1'b0;
      overflowSet <= 1'b0;
      interruptEnableSet <= 1'b0;
      interruptEnableClear <= 1'b0;
      dma1FlagBufSet <= 1'b0;
      dma2FlagBufSet <= 1'b0;
      cardFlagBufSet <= 1'b0;
    end else begin
      // [RL12] [RL24]
      set_control_instr <= groupLive && octal[GRP_CONTROL] && isT4
                           && !instrReg[IR_AB_SEL];
      clear_control_instr <= groupLive && octal[GRP_CONTROL] && isT4
                             && instrReg[IR_AB_SEL];
      control_reset_broadcast <= groupLive && octal[GRP_CONTROL] && isT4
                                 && instrReg[IR_AB_SEL] && sel01; // [RL13]
      interruptInhibitClear <= groupLive && ((octal[GRP_CONTROL] && isT4)
                               || (octal[GRP_FLAG] && isT3)); // [RL12]
      control4Set <= groupLive && octal[GRP_CONTROL] && isT4
                     && !instrReg[IR_AB_SEL] && select_code_four;
      dma1ControlSet <= groupLive && octal[GRP_CONTROL] && isT4
                        && !instrReg[IR_AB_SEL] && sel06;
      dma1ControlClear <= groupLive && octal[GRP_CONTROL] && isT4
                          && instrReg[IR_AB_SEL] && sel06;
      dma2ControlSet <= groupLive && octal[GRP_CONTROL] && isT4
                        && !instrReg[IR_AB_SEL] && sel07;
      dma2ControlClear <= groupLive && octal[GRP_CONTROL] && isT4
                          && instrReg[IR_AB_SEL] && sel07;
      cardControlSet <= groupLive && octal[GRP_CONTROL] && isT4
                        && !instrReg[IR_AB_SEL] && cardSelect;
      cardControlClear <= groupLive && octal[GRP_CONTROL] && isT4
                          && instrReg[IR_AB_SEL] && cardSelect;
      // [RL16] [RL24]
      set_flag_strobe <= groupLive && octal[GRP_FLAG] && isT3;
      overflowSet <= groupLive && octal[GRP_FLAG] && isT3 && sel01;
      interruptEnableSet <= groupLive && octal[GRP_FLAG] && isT3 && sel00;
      dma1FlagBufSet <= groupLive && octal[GRP_FLAG] && isT3 && sel06;
      dma2FlagBufSet <= groupLive && octal[GRP_FLAG] && isT3 && sel07;
      cardFlagBufSet <= groupLive && octal[GRP_FLAG] && isT3 && cardSelect;
      // Clear at T4 overrides the T3 set on the same flag
      clear_flag_strobe <= groupLive && octal[GRP_FLAG] && isT4
                           && instrReg[IR_CLEAR_FLAG]; // [RL17]
      interruptEnableClear <= groupLive && octal[GRP_FLAG] && isT4
                              && instrReg[IR_CLEAR_FLAG] && sel00; // [RL17]
    end
  end

  // Skip tests, gated by group enable T3..T6
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      skipFlag <= 1'b0;
    end else if (groupLive && octal[GRP_SKIP_SET]) begin
      skipFlag <= sel01 ? !overflow_not_flop :
                  sel06 ? dma1_flag :
                  sel07 ? dma2_flag :
                  sel00 ? interruptEnableSet :
                  (cardSelect && card_flag_signal); // [RL14]
    end else if (groupLive && octal[GRP_SKIP_CLEAR]) begin
      skipFlag <= sel01 ? overflow_not_flop :
                  sel06 ? !dma1_flag :
                  sel07 ? !dma2_flag :
                  sel00 ? !interruptEnableSet :
                  select_code_four ? !powerfail_direction_flop :
                  (cardSelect && !card_flag_signal); // [RL15]
    end else begin
      skipFlag <= 1'b0;
    end
  end

  // Output strobe and its destinations, T3T4
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      output_strobe <= 1'b0;
      fenceLoad <= 1'b0;
      dmaControlLoad1 <= 1'b0;
      dmaControlLoad2 <= 1'b0;
      panelLoad <= 1'b0;
      cardDataLoad <= 1'b0;
      send_io_buffer <= 1'b0;
      io_data_lines_oe <= 1'b0;
      io_data_lines_out <= '0;
    end else begin
      output_strobe <= groupLive && octal[GRP_OUTPUT]
                       && (isT3 || isT4); // [RL18]
      fenceLoad <= groupLive && octal[GRP_OUTPUT] && isT4 && sel05;
      dmaControlLoad1 <= groupLive && octal[GRP_OUTPUT] && isT4 && sel06;
      dmaControlLoad2 <= groupLive && octal[GRP_OUTPUT] && isT4 && sel07;
      panelLoad <= groupLive && octal[GRP_OUTPUT] && isT4 && sel01;
      cardDataLoad <= groupLive && octal[GRP_OUTPUT] && isT4 && cardSelect;
      send_io_buffer <= groupLive && octal[GRP_OUTPUT]
                        && (isT4 || isT5); // [RL23]
      io_data_lines_oe <= groupLive && octal[GRP_OUTPUT]
                          && (isT4 || isT5); // [RL23]
      io_data_lines_out <= accSel; // [RL23]
    end
  end

  // Input side: read buffer, source register reads, accumulator writes
  always_comb begin
    sBus_next = '0;
    if (readSrcNow || (groupLive && inSrc)) begin
      sBus_next = srcWord; // [RL4] [RL6]
    end else if (groupLive && (mergeOp || octal[GRP_LOAD])
                 && (isT4 || isT5)) begin
      sBus_next = io_data_lines_in; // [RL20]
    end else if (groupLive && octal[GRP_OUTPUT]) begin
      sBus_next = accSel;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sBus <= '0;
      input_strobe <= 1'b0;
      read_io_buffer <= 1'b0;
      read_interrupt_source <= 1'b0;
      accWriteData <= '0;
      accAWrite <= 1'b0;
      accBWrite <= 1'b0;
    end else begin
      sBus <= sBus_next;
      input_strobe <= groupLive && (mergeOp || octal[GRP_LOAD])
                      && (isT4 || isT5); // [RL6]
      read_io_buffer <= groupLive && (mergeOp || octal[GRP_LOAD])
                        && (isT4 || isT5) && !select_code_four; // [RL20]
      read_interrupt_source <= readSrcNow || (groupLive && inSrc); // [RL4]
      // Merge ORs accumulator in; load replaces it
      accWriteData <= mergeOp ? (accSel | sBus_next)
                              : sBus_next; // [RL21] [RL22] [RL5]
      accAWrite <= groupLive && (mergeOp || octal[GRP_LOAD]) && isT5
                   && !instrReg[IR_AB_SEL]; // [RL6]
      accBWrite <= groupLive && (mergeOp || octal[GRP_LOAD]) && isT5
                   && instrReg[IR_AB_SEL]; // [RL6]
    end
  end

  // Request clear in the final window of phase 1B only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqCnt_reg <= '0;
      requestClear <= 1'b0;
    end else if (fetchPhase1B && isT6) begin
      if (reqCnt_reg != 3'(REQ_CLEAR_CYCLES)) begin
        reqCnt_reg <= reqCnt_reg + 3'h1;
      end
      requestClear <= captureEn && (reqCnt_reg < 3'(REQ_CLEAR_CYCLES)); // [RL3]
    end else begin
      reqCnt_reg <= '0;
      requestClear <= 1'b0;
    end
  end

endmodule

// ### dv/io_group_decoder_asserts.sv
`timescale 1ns/1ps
module io_group_decoder_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ioViolation,
  input wire logic cpuClockHold,
  input wire logic io_group_enable,
  input wire logic set_control_instr,
  input wire logic clear_control_instr,
  input wire logic control_reset_broadcast,
  input wire logic set_flag_strobe,
  input wire logic clear_flag_strobe,
  input wire logic output_strobe,
  input wire logic io_data_lines_oe,
  input wire logic read_io_buffer,
  input wire logic read_interrupt_source,
  input wire logic [15:0] sBus,
  input wire logic accAWrite,
  input wire logic accBWrite
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ctrl_excl;
    !(set_control_instr && clear_control_instr);
  endproperty
  a_ctrl_excl: assert property (p_ctrl_excl)
    else $error("set and clear control together");
  property p_crs;
    control_reset_broadcast |-> clear_control_instr;
  endproperty
  a_crs: assert property (p_crs)
    else $error("control reset without clear control");
  property p_grp_en;
    (set_control_instr || clear_control_instr || set_flag_strobe ||
      output_strobe) |-> io_group_enable;
  endproperty
  a_grp_en: assert property (p_grp_en)
    else $error("group strobe outside group enable");
  property p_flag_excl;
    !(set_flag_strobe && clear_flag_strobe);
  endproperty
  a_flag_excl: assert property (p_flag_excl)
    else $error("set and clear flag together");
  property p_clf_after_stf;
    $rose(clear_flag_strobe) |-> $past(set_flag_strobe);
  endproperty
  a_clf_after_stf: assert property (p_clf_after_stf)
    else $error("clear flag not preceded by set flag");
  property p_oe_after_out;
    $rose(io_data_lines_oe) |-> $past(output_strobe);
  endproperty
  a_oe_after_out: assert property (p_oe_after_out)
    else $error("bus drive not preceded by output strobe");
  property p_hold_before_en;
    $rose(io_group_enable) |-> !cpuClockHold;
  endproperty
  a_hold_before_en: assert property (p_hold_before_en)
    else $error("group enable while clocks held");
  property p_src_zext;
    read_interrupt_source |-> sBus[15:6] == 10'h000;
  endproperty
  a_src_zext: assert property (p_src_zext)
    else $error("source read not zero extended");
  // Violation mid-cycle may cut the enable short
  property p_en_width;
    $rose(io_group_enable) |-> (io_group_enable || ioViolation)[*4];
  endproperty
  a_en_width: assert property (p_en_width)
    else $error("group enable shorter than four states");
  property p_acc_after_in;
    (accAWrite || accBWrite) |-> (read_io_buffer || read_interrupt_source);
  endproperty
  a_acc_after_in: assert property (p_acc_after_in)
    else $error("accumulator written without buffer read");
  c_control: cover property (set_control_instr);
  c_source: cover property (read_interrupt_source);
  c_merge: cover property (accBWrite && read_io_buffer);
endmodule

bind io_group_decoder io_group_decoder_asserts u_io_group_decoder_asserts (.*);

// ### dv/card_model.sv
`timescale 1ns/1ps
module card_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic read_io_buffer,
  input wire logic output_strobe,
  input wire logic io_data_lines_oe,
  input wire logic [15:0] io_data_lines_out,
  input wire logic requestClear,
  input wire logic reqPulse,
  input wire logic [5:0] reqValue,
  input wire logic [15:0] cardData,
  output logic [15:0] io_data_lines_in,
  output logic [5:0] requestAddr,
  output logic [15:0] rxData
);
  logic reqActive;
  logic [5:0] addrHeld;
  logic [15:0] fill;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqActive <= 1'b0;
      addrHeld <= 6'h00;
      fill <= 16'hA5C3;
      rxData <= 16'h0000;
    end else begin
      // Undriven bus shows a pattern that flips every cycle
      fill <= ~fill;
      if (reqPulse)
        reqActive <= 1'b1;
      else if (requestClear)
        reqActive <= 1'b0;
      if (reqPulse)
        addrHeld <= reqValue;
      if (output_strobe && io_data_lines_oe)
        rxData <= io_data_lines_out;
    end
  end
  assign io_data_lines_in = read_io_buffer ? cardData : fill;
  assign requestAddr = reqActive ? addrHeld : ~addrHeld;
endmodule

// ### dv/io_group_decode_and_interrupt_address_test.sv
`timescale 1ns/1ps
module io_group_decode_and_interrupt_address_test;
  import io_group_pkg::*;
  logic clk, rst_b, ioAdvance, execPhase, fetchPhase1B, ioViolation;
  logic io_group_sync_code, interrupt_source_read_code, reqPulse;
  logic sel00, sel01, select_code_four, sel05, sel06, sel07, cardSelect;
  logic card_flag_signal, overflow_not_flop, dma1_flag, dma2_flag;
  logic powerfail_direction_flop;
  logic [IR_WIDTH-1:0] instrReg;
  logic [ADDR_WIDTH-1:0] requestAddr, reqValue;
  logic [DATA_WIDTH-1:0] accA, accB, io_data_lines_in, cardData, rxData;
  logic [DATA_WIDTH-1:0] sBus, io_data_lines_out, accWriteData, srcValue;
  logic [7:0] microAddr;
  logic cpuClockHold, io_group_enable, set_control_instr;
  logic clear_control_instr, control_reset_broadcast, interruptInhibitClear;
  logic control4Set, dma1ControlSet, dma1ControlClear, dma2ControlSet;
  logic dma2ControlClear, cardControlSet, cardControlClear, skipFlag;
  logic set_flag_strobe, clear_flag_strobe, overflowSet, interruptEnableSet;
  logic interruptEnableClear, dma1FlagBufSet, dma2FlagBufSet, cardFlagBufSet;
  logic output_strobe, fenceLoad, dmaControlLoad1, dmaControlLoad2;
  logic panelLoad, cardDataLoad, input_strobe, read_io_buffer;
  logic send_io_buffer, read_interrupt_source, io_data_lines_oe;
  logic accAWrite, accBWrite, requestClear;
  int fails, samples_checked;
  int sels[7] = '{0, 1, 4, 5, 6, 7, 8};
  wire logic [33:0] obs = {cpuClockHold, io_group_enable, set_control_instr,
    clear_control_instr, control_reset_broadcast, interruptInhibitClear,
    control4Set, dma1ControlSet, dma1ControlClear, dma2ControlSet,
    dma2ControlClear, cardControlSet, cardControlClear, skipFlag,
    set_flag_strobe, clear_flag_strobe, interruptEnableSet, dma1FlagBufSet,
    dma2FlagBufSet, cardFlagBufSet, output_strobe, fenceLoad,
    dmaControlLoad1, dmaControlLoad2, panelLoad, cardDataLoad, input_strobe,
    read_io_buffer, io_data_lines_oe, send_io_buffer, accAWrite, accBWrite,
    overflowSet, interruptEnableClear};

  io_group_decoder u_io_group_decoder (.*);
  card_model u_card_model (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (exp !== got) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Select 8 stands for an ordinary interface card
  task automatic run(input logic [2:0] g, input int s, input logic v);
    logic i9, i11, src, ok, sc, cc, sf, o, di, sk, c;
    logic [33:0] e, seen;
    logic [DATA_WIDTH-1:0] d, wr;
    logic [7:0] ua;
    int en;
    i9 = 1'($urandom);
    i11 = 1'($urandom);
    accA = 16'($urandom);
    accB = 16'($urandom);
    cardData = 16'($urandom);
    dma1_flag = 1'($urandom);
    dma2_flag = 1'($urandom);
    card_flag_signal = 1'($urandom);
    overflow_not_flop = 1'($urandom);
    powerfail_direction_flop = 1'($urandom);
    instrReg = {4'h0, i11, 1'b0, i9, g, 6'(s)};
    {cardSelect, sel07, sel06, sel05, select_code_four, sel01, sel00} =
      {s == 8, s == 7, s == 6, s == 5, s == 4, s == 1, s == 0};
    ioViolation = v;
    execPhase = 1'b1;
    @(posedge clk);
    #1 execPhase = 1'b0;
    ua = g == 4 ? UADDR_MERGE : g == 5 ? UADDR_LOAD : g == 6 ? UADDR_OUTPUT
      : g == 7 ? UADDR_CTRL : UADDR_FLAG;
    chk("entry", 32'(ua), 32'(microAddr));
    io_group_sync_code = 1'b1;
    seen = '0;
    wr = '0;
    en = 0;
    repeat (16) begin
      @(posedge clk);
      #1 io_group_sync_code = 1'b0;
      seen |= obs;
      en += (io_group_enable === 1'b1) ? 1 : 0;
      if (accAWrite === 1'b1 || accBWrite === 1'b1)
        wr = accWriteData;
    end
    c = s == 8;
    ok = !v;
    // No enable state reaches the block, so select 00 reads as disabled
    src = s == 1 ? !overflow_not_flop : s == 6 ? dma1_flag
      : s == 7 ? dma2_flag : c && card_flag_signal;
    sc = ok && g == 7 && !i11;
    cc = ok && g == 7 && i11;
    sf = ok && g == 1;
    o = ok && g == 6;
    di = ok && (g == 4 || g == 5);
    sk = ok && (g == 3 ? src : g == 2 && (s == 4 ? !powerfail_direction_flop
      : s != 5 && !src));
    e = {1'b1, ok, sc, cc, cc && s == 1, ok && (g == 7 || g == 1),
      sc && s == 4, sc && s == 6, cc && s == 6, sc && s == 7, cc && s == 7,
      sc && c, cc && c, sk, sf, sf && i9, sf && s == 0, sf && s == 6,
      sf && s == 7, sf && c, o, o && s == 5, o && s == 6, o && s == 7,
      o && s == 1, o && c, di, di && s != 4, o, o, di && !i11, di && i11,
      sf && s == 1, sf && i9 && s == 0};
    chk("strobes", e[33:2], seen[33:2]);
    chk("flag_dests", 32'(e[1:0]), 32'(seen[1:0]));
    chk("enable_cycles", ok ? 32'd4 : 32'd0, 32'(en));
    d = (s == 4) ? srcValue : cardData;
    if (g == 4)
      d = d | (i11 ? accB : accA);
    if (di)
      chk("acc_data", 32'(d), 32'(wr));
    if (o)
      chk("out_data", 32'(i11 ? accB : accA), 32'(rxData));
    $display("test group %0d select %0d done", g, s);
  endtask

  task automatic fetch(input logic [ADDR_WIDTH-1:0] a);
    logic [31:0] got;
    logic cleared;
    int n;
    reqValue = a;
    reqPulse = 1'b1;
    @(posedge clk);
    #1 reqPulse = 1'b0;
    fetchPhase1B = 1'b1;
    interrupt_source_read_code = 1'b1;
    got = '1;
    cleared = 1'b0;
    n = 0;
    // Leave 1B as soon as the request drops, so T6 is seen only once
    while (!cleared && n < 8) begin
      @(posedge clk);
      #1 n++;
      if (read_interrupt_source === 1'b1)
        got = 32'(sBus);
      cleared = (requestClear === 1'b1);
    end
    fetchPhase1B = 1'b0;
    interrupt_source_read_code = 1'b0;
    srcValue = 16'(a);
    chk("source_read", 32'(a), got);
    chk("request_clear", 32'h1, 32'(cleared));
    $display("test fetch %h done", a);
  endtask

  initial begin
    #200000;
    fails++;
    test_done;
  end

  initial begin
    void'($urandom(72489));
    {rst_b, execPhase, fetchPhase1B, ioViolation, reqPulse} = '0;
    {io_group_sync_code, interrupt_source_read_code} = '0;
    {sel00, sel01, select_code_four, sel05, sel06, sel07, cardSelect} = '0;
    {card_flag_signal, overflow_not_flop, dma1_flag, dma2_flag} = '0;
    {powerfail_direction_flop, instrReg, reqValue, accA, accB} = '0;
    {cardData, srcValue} = '0;
    ioAdvance = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    run(3'h5, 4, 1'b0);
    fetch(6'($urandom_range(8, 63)));
    for (int g = 0; g < 8; g++) begin
      foreach (sels[k])
        run(3'(g), sels[k], 1'b0);
    end
    run(3'h7, 8, 1'b1);
    fetch(6'($urandom_range(8, 63)));
    run(3'h4, 4, 1'b0);
    test_done;
  end
endmodule
